// ==== hw/cpu_core_regs.sv ====
// core register set: accumulator, index pair, program counter, flags, stack
// assumes an instruction sequencer drives one-cycle command pulses while o_busy is low
//
// Notes on behaviour
// - 16-bit program counter of two bytes, plus accumulator and two index registers.
// - flags byte; top three bits read one; low five are H, I, N, Z, C.
// - add and add-with-carry set H on carry from bit 3, else clear.
// - mask set on interrupt entry or by software; cleared by software or interrupt return.
// - requests arriving while masked stay pending until the mask clears.
// - interrupt return clears the mask; cleared mask lets pending requests in.
// - negative flag copies bit 7 of each operation result.
// - zero flag set when the result is zero, else cleared.
// - carry from arithmetic, set/clear ops, and bit-test, shift, rotate loads.
// - flags push and pop through the stack; each flag controllable.
// - stack pointer names next free byte; decrement after push, increment before pop.
// - stack is 64 bytes; ten upper pointer bits are fixed.
// - reset and reload op set the six variable pointer bits.
// - pointer wraps silently both ways, overwriting older bytes.
// - interrupt entry stores program counter low at the first addressed byte.
// - interrupt entry and return never touch the second index register.
// - a call takes two stack bytes, an interrupt five.
// - pointer low byte readable; the load op writes only its low six bits.
// - prefix op makes the next instruction use the second index register.
`timescale 1ns/10ps
`include "cpu_regs_map.svh"
module cpu_core_regs
  import cpu_regs_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // instruction framing
  input wire logic i_instr_boundary,
  input wire logic i_prefix_op,
  // register writes
  input wire logic i_acc_we,
  input wire logic [7:0] i_acc_wdata,
  input wire logic i_index_we,
  input wire logic [7:0] i_index_wdata,
  input wire logic i_pc_load,
  input wire logic [15:0] i_pc_wdata,
  input wire logic i_pc_inc,
  // alu
  input wire logic i_alu_valid,
  input wire alu_kind_e i_alu_kind,
  input wire logic [7:0] i_alu_a,
  input wire logic [7:0] i_alu_b,
  input wire logic i_alu_to_acc,
  // flag ops
  input wire logic i_set_carry_op,
  input wire logic i_clear_carry_op,
  input wire logic i_carry_load,
  input wire logic i_carry_value,
  input wire logic i_mask_interrupts_op,
  input wire logic i_unmask_interrupts_op,
  // stack ops
  input wire logic i_push_op,
  input wire logic i_pop_op,
  input wire stack_reg_e i_stack_reg,
  input wire logic i_call_op,
  input wire logic [15:0] i_call_target,
  input wire logic i_return_op,
  input wire logic i_interrupt_return_op,
  input wire logic i_stack_pointer_reload_op,
  input wire logic i_sp_low_we,
  input wire logic [7:0] i_sp_low_wdata,
  // interrupts
  input wire logic i_irq_req,
  input wire logic i_trap_op,
  input wire logic [15:0] i_irq_vector,
  // register view
  output logic [7:0] o_acc,
  output logic [7:0] o_index_x,
  output logic [7:0] o_index_y,
  output logic o_index_sel_y,
  output logic [15:0] o_program_counter,
  output logic [7:0] o_condition_flags,
  output logic [15:0] o_stack_pointer,
  // status
  output logic o_irq_pending,
  output logic o_irq_entry,
  output logic o_busy
);
  logic [7:0] acc;
  logic [7:0] index_x;
  logic [7:0] index_y;
  logic prefix_y;
  logic [15:0] program_counter;
  logic [4:0] flags;
  logic [5:0] sp6;
  logic irq_pending;
  logic [7:0] stack_mem [64];
  state_e state;
  seq_e seq;
  logic [2:0] slot;
  logic [15:0] target;
  logic [7:0] alu_res;
  logic alu_half;
  logic alu_carry;
  logic idle;
  logic entry_go;
  logic op_go;
  logic alu_go;
  logic push_wr;
  logic [7:0] push_data;
  logic [7:0] pop_data;
  logic flags_pop;

  function automatic logic is_arith(input alu_kind_e k);
    return (k == ALU_ADD) || (k == ALU_ADC) || (k == ALU_SUB);
  endfunction

  // context byte for each slot of an interrupt or call frame
  function automatic logic [7:0] slot_byte(input logic [2:0] s, input logic [15:0] pc,
                                           input logic [7:0] x, input logic [7:0] a,
                                           input logic [4:0] f);
    unique case (s)
      3'h0: return pc[7:0];
      3'h1: return pc[15:8];
      3'h2: return x;
      3'h3: return a;
      3'h4: return {`FLAGS_ONES, f};
      default: return 8'h00;
    endcase
  endfunction

  alu_flag_unit u_alu (
    .i_kind(i_alu_kind),
    .i_a(i_alu_a),
    .i_b(i_alu_b),
    .i_carry_in(flags[`FLAG_C]),
    .o_result(alu_res),
    .o_half(alu_half),
    .o_carry(alu_carry)
  );

  assign idle = (state == ST_IDLE);
  assign entry_go = idle && i_instr_boundary && (i_trap_op || (irq_pending && !flags[`FLAG_I]));
  assign op_go = idle && !entry_go;
  assign alu_go = op_go && i_alu_valid;
  assign push_wr = (state == ST_PUSH) || (op_go && i_push_op);
  assign push_data = (state == ST_PUSH) ? slot_byte(slot, program_counter, index_x, acc, flags)
                   : slot_byte((i_stack_reg == SRC_FLAGS) ? 3'h4 : 3'h3, program_counter, index_x,
                               (i_stack_reg == SRC_X) ? index_x : (i_stack_reg == SRC_Y) ? index_y : acc, flags);
  assign pop_data = stack_mem[sp6 + 6'h01];
  assign flags_pop = op_go && i_pop_op && (i_stack_reg == SRC_FLAGS);

  assign o_acc = acc;
  assign o_index_x = index_x;
  assign o_index_y = index_y;
  assign o_index_sel_y = prefix_y;
  assign o_program_counter = program_counter;
  assign o_condition_flags = {`FLAGS_ONES, flags};
  assign o_stack_pointer = {`SP_FIXED_HI, sp6};
  assign o_irq_pending = irq_pending;
  assign o_irq_entry = entry_go;
  assign o_busy = !idle;

  // frame sequencer
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state <= ST_IDLE;
      seq <= SEQ_IRQ;
      slot <= 3'h0;
      target <= `PC_RESET;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (entry_go) begin
            state <= ST_PUSH;
            seq <= SEQ_IRQ;
            slot <= 3'h0;
            target <= i_irq_vector;
          end else if (op_go && i_call_op) begin
            state <= ST_PUSH;
            seq <= SEQ_CALL;
            slot <= 3'h0;
            target <= i_call_target;
          end else if (op_go && i_interrupt_return_op) begin
            state <= ST_POP;
            seq <= SEQ_INTERRUPT_RETURN_OP;
            slot <= `SLOT_LAST_IRQ;
          end else if (op_go && i_return_op) begin
            state <= ST_POP;
            seq <= SEQ_RET;
            slot <= `SLOT_LAST_CALL;
          end
        end
        ST_PUSH: begin
          slot <= slot + 3'h1;
          if (slot == ((seq == SEQ_IRQ) ? `SLOT_LAST_IRQ : `SLOT_LAST_CALL)) begin
            state <= ST_IDLE;
          end
        end
        ST_POP: begin
          slot <= slot - 3'h1;
          if (slot == 3'h0) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // stack storage has no reset; stale bytes are simply overwritten on wrap
  always_ff @(posedge i_ref_clk) begin
    if (push_wr) begin
      stack_mem[sp6] <= push_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sp6 <= `SP_LOW_TOP;
    end else if (state == ST_PUSH || (op_go && i_push_op)) begin
      sp6 <= sp6 - 6'h01;
    end else if (state == ST_POP || (op_go && i_pop_op)) begin
      sp6 <= sp6 + 6'h01;
    end else if (op_go && i_stack_pointer_reload_op) begin
      sp6 <= `SP_LOW_TOP;
    end else if (op_go && i_sp_low_we) begin
      sp6 <= i_sp_low_wdata[5:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      program_counter <= `PC_RESET;
    end else if (state == ST_PUSH && slot == ((seq == SEQ_IRQ) ? `SLOT_LAST_IRQ : `SLOT_LAST_CALL)) begin
      program_counter <= target;
    end else if (state == ST_POP && slot == 3'h1) begin
      program_counter[15:8] <= pop_data;
    end else if (state == ST_POP && slot == 3'h0) begin
      program_counter[7:0] <= pop_data;
    end else if (op_go && i_pc_load) begin
      program_counter <= i_pc_wdata;
    end else if (op_go && i_pc_inc) begin
      program_counter <= program_counter + 16'h0001;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      acc <= 8'h00;
    end else if (state == ST_POP && seq == SEQ_INTERRUPT_RETURN_OP && slot == 3'h3) begin
      acc <= pop_data;
    end else if (op_go && i_pop_op && i_stack_reg == SRC_ACC) begin
      acc <= pop_data;
    end else if (alu_go && i_alu_to_acc) begin
      acc <= alu_res;
    end else if (op_go && i_acc_we) begin
      acc <= i_acc_wdata;
    end
  end

  // second index is written only by explicit ops, never by the frame sequencer
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      index_x <= 8'h00;
      index_y <= 8'h00;
    end else if (state == ST_POP && seq == SEQ_INTERRUPT_RETURN_OP && slot == 3'h2) begin
      index_x <= pop_data;
    end else if (op_go && i_pop_op && i_stack_reg == SRC_X) begin
      index_x <= pop_data;
    end else if (op_go && i_pop_op && i_stack_reg == SRC_Y) begin
      index_y <= pop_data;
    end else if (op_go && i_index_we && prefix_y) begin
      index_y <= i_index_wdata;
    end else if (op_go && i_index_we) begin
      index_x <= i_index_wdata;
    end
  end

  // prefix lasts until the next instruction boundary; a new prefix wins
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      prefix_y <= 1'b0;
    end else if (op_go && i_prefix_op) begin
      prefix_y <= 1'b1;
    end else if (i_instr_boundary) begin
      prefix_y <= 1'b0;
    end
  end

  // a request in the cycle of entry stays pending for the next one
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      irq_pending <= 1'b0;
    end else if (i_irq_req) begin
      irq_pending <= 1'b1;
    end else if (entry_go && !i_trap_op) begin
      irq_pending <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      flags <= `FLAGS_RESET_LOW;
    end else if (entry_go) begin
      flags[`FLAG_I] <= 1'b1;
    end else if (state == ST_POP && seq == SEQ_INTERRUPT_RETURN_OP && slot == `SLOT_LAST_IRQ) begin
      flags <= {pop_data[4], 1'b0, pop_data[2:0]};
    end else if (flags_pop) begin
      flags <= pop_data[4:0];
    end else if (op_go) begin
      if (alu_go) begin
        flags[`FLAG_N] <= alu_res[7];
        flags[`FLAG_Z] <= (alu_res == 8'h00);
        if (i_alu_kind == ALU_ADD || i_alu_kind == ALU_ADC) begin
          flags[`FLAG_H] <= alu_half;
        end
        if (is_arith(i_alu_kind)) begin
          flags[`FLAG_C] <= alu_carry;
        end
      end
      if (i_carry_load) begin
        flags[`FLAG_C] <= i_carry_value;
      end
      if (i_clear_carry_op) begin
        flags[`FLAG_C] <= 1'b0;
      end
      if (i_set_carry_op) begin
        flags[`FLAG_C] <= 1'b1;
      end
      if (i_unmask_interrupts_op) begin
        flags[`FLAG_I] <= 1'b0;
      end
      if (i_mask_interrupts_op) begin
        flags[`FLAG_I] <= 1'b1;
      end
    end
  end

  // checks
  logic hc_expect;
  assign hc_expect = (({1'b0, i_alu_a[3:0]} + {1'b0, i_alu_b[3:0]}) > 5'h0f);
  logic [7:0] pcl_now;
  assign pcl_now = program_counter[7:0];

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  a_flags_top_ones: assert property (
    o_condition_flags[7:5] == 3'b111) else $error("flags top bits not one");
  a_half_carry_add: assert property (
    alu_go && i_alu_kind == ALU_ADD && !i_carry_load |=> flags[`FLAG_H] == $past(hc_expect))
    else $error("half carry wrong after add");
  a_mask_on_entry: assert property (
    entry_go |=> flags[`FLAG_I] [*5]) else $error("mask not held during entry");
  a_pending_held: assert property (
    irq_pending && flags[`FLAG_I] && !entry_go |=> irq_pending) else $error("masked request lost");
  a_interrupt_return_op_unmask: assert property (
    state == ST_POP && seq == SEQ_INTERRUPT_RETURN_OP && slot == 3'h4 |=> !flags[`FLAG_I])
    else $error("interrupt return left mask set");
  a_neg_follows: assert property (
    alu_go && !flags_pop |=> flags[`FLAG_N] == $past(alu_res[7])) else $error("negative flag wrong");
  a_zero_follows: assert property (
    alu_go && !flags_pop |=> flags[`FLAG_Z] == ($past(alu_res) == 8'h00)) else $error("zero flag wrong");
  a_set_carry: assert property (
    op_go && i_set_carry_op && !flags_pop |=> flags[`FLAG_C]) else $error("carry not set");
  a_sp_fixed_bits: assert property (
    o_stack_pointer[15:6] == 10'h003) else $error("stack pointer fixed bits changed");
  a_sp_reload_top: assert property (
    op_go && i_stack_pointer_reload_op && !i_push_op && !i_pop_op |=> sp6 == 6'h3f)
    else $error("reload did not reach top");
  a_irq_five_bytes: assert property (
    entry_go |-> ##6 (sp6 == $past(sp6, 6) - 6'h05) && idle) else $error("interrupt frame not five bytes");
  a_call_two_bytes: assert property (
    op_go && i_call_op |-> ##3 (sp6 == $past(sp6, 3) - 6'h02) && idle) else $error("call frame not two bytes");
  a_y_untouched: assert property (
    !idle |=> $stable(index_y)) else $error("second index changed by frame");
  a_pcl_first: assert property (
    entry_go |=> ##1 stack_mem[$past(sp6, 2)] == $past(pcl_now, 2))
    else $error("entry did not start with low byte");

  c_irq_entry: cover property (entry_go ##6 idle);
  c_interrupt_return_op: cover property (op_go && i_interrupt_return_op ##6 idle);
  c_call: cover property (op_go && i_call_op);
  c_sp_wrap: cover property (push_wr && sp6 == 6'h00);
endmodule

// ==== common/cpu_regs_map.svh ====
// constants of the core register set: flag positions, reset values, stack layout
// assumes inclusion by bare name from the package and the design files
`ifndef CPU_REGS_MAP_SVH
`define CPU_REGS_MAP_SVH

`define FLAG_H 4
`define FLAG_I 3
`define FLAG_N 2
`define FLAG_Z 1
`define FLAG_C 0
`define FLAGS_ONES 3'b111
`define FLAGS_RESET_LOW 5'h08
`define SP_RESET 16'h00ff
`define SP_FIXED_HI 10'h003
`define SP_LOW_TOP 6'h3f
`define PC_RESET 16'h0000
`define SLOT_LAST_CALL 3'h1
`define SLOT_LAST_IRQ 3'h4

`endif

// ==== common/cpu_regs_pkg.sv ====
// types shared by the core register set and its flag unit
// assumes cpu_regs_map.svh on the include path
package cpu_regs_pkg;
  typedef enum logic [2:0] {
    ALU_ADD = 3'b000,
    ALU_ADC = 3'b001,
    ALU_SUB = 3'b010,
    ALU_AND = 3'b011,
    ALU_OR = 3'b100,
    ALU_XOR = 3'b101,
    ALU_MOVE = 3'b110
  } alu_kind_e;

  typedef enum logic [1:0] {
    SRC_ACC = 2'b00,
    SRC_X = 2'b01,
    SRC_Y = 2'b10,
    SRC_FLAGS = 2'b11
  } stack_reg_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PUSH = 2'b01,
    ST_POP = 2'b10
  } state_e;

  typedef enum logic [1:0] {
    SEQ_IRQ = 2'b00,
    SEQ_CALL = 2'b01,
    SEQ_INTERRUPT_RETURN_OP = 2'b10,
    SEQ_RET = 2'b11
  } seq_e;
endpackage

// ==== hw/alu_flag_unit.sv ====
// combinational 8-bit adder/logic unit with half-carry and carry out
// assumes the caller registers result and flags
`timescale 1ns/10ps
module alu_flag_unit
  import cpu_regs_pkg::*;
(
  // operands
  input wire alu_kind_e i_kind,
  input wire logic [7:0] i_a,
  input wire logic [7:0] i_b,
  input wire logic i_carry_in,
  // results
  output logic [7:0] o_result,
  output logic o_half,
  output logic o_carry
);
  always_comb begin
    logic [8:0] sum;
    logic [4:0] nib;
    logic cin;
    sum = 9'h000;
    nib = 5'h00;
    cin = (i_kind == ALU_ADC) ? i_carry_in : 1'b0;
    o_result = 8'h00;
    o_half = 1'b0;
    o_carry = i_carry_in;
    unique case (i_kind)
      ALU_ADD, ALU_ADC: begin
        nib = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, cin};
        sum = {1'b0, i_a} + {1'b0, i_b} + {8'h00, cin};
        o_result = sum[7:0];
        o_half = nib[4];
        o_carry = sum[8];
      end
      ALU_SUB: begin
        // bit 8 of the difference is the borrow
        sum = {1'b0, i_a} - {1'b0, i_b};
        o_result = sum[7:0];
        o_carry = sum[8];
      end
      ALU_AND: o_result = i_a & i_b;
      ALU_OR: o_result = i_a | i_b;
      ALU_XOR: o_result = i_a ^ i_b;
      ALU_MOVE: o_result = i_b;
      default: o_result = 8'h00;
    endcase
  end
endmodule

// ==== test/seq_partner_model.sv ====
// stand-in for the sequencer: instruction-boundary and interrupt-request pulses
// assumes the bench holds i_step or i_raise high for at least one cycle
`timescale 1ns/10ps
module seq_partner_model (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // bench requests
  input wire logic i_step,
  input wire logic i_raise,
  // toward the register set
  output logic o_boundary,
  output logic o_irq_req
);
  logic step_d;
  logic raise_d;

  // edge to pulse, so a held level never reads as a burst of requests
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      step_d <= 1'b0;
      raise_d <= 1'b0;
      o_boundary <= 1'b0;
      o_irq_req <= 1'b0;
    end else begin
      step_d <= i_step;
      raise_d <= i_raise;
      o_boundary <= i_step & ~step_d;
      o_irq_req <= i_raise & ~raise_d;
    end
  end
endmodule

// ==== test/test_cpu_core_regs.sv ====
// self-checking bench for the core register set, commands issued as one-cycle pulses
// assumes the sequencer stand-in makes boundary and interrupt pulses on request
`timescale 1ns/10ps
module test_cpu_core_regs;
  import cpu_regs_pkg::*;
  localparam logic [15:0] PUSH = 16'h0001;
  localparam logic [15:0] POP = 16'h0002;
  localparam logic [15:0] CALL = 16'h0004;
  localparam logic [15:0] RET = 16'h0008;
  localparam logic [15:0] INTERRUPT_RETURN_OP = 16'h0010;
  localparam logic [15:0] RELOAD = 16'h0020;
  localparam logic [15:0] SPW = 16'h0040;
  localparam logic [15:0] ALU = 16'h0080;
  localparam logic [15:0] SETC = 16'h0100;
  localparam logic [15:0] CLRC = 16'h0200;
  localparam logic [15:0] MASK = 16'h0400;
  localparam logic [15:0] UNMASK = 16'h0800;
  localparam logic [15:0] PREFIX = 16'h1000;
  localparam logic [15:0] XW = 16'h2000;
  localparam logic [15:0] AW = 16'h4000;
  localparam logic [15:0] PCW = 16'h8000;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [15:0] ops = 16'h0000;
  logic i_step = 1'b0;
  logic i_raise = 1'b0;
  logic boundary;
  logic irq_req;
  logic [7:0] wdata = 8'h00;
  logic [15:0] wide = 16'h0000;
  alu_kind_e kind = ALU_ADD;
  logic [7:0] alu_a = 8'h00;
  logic [7:0] alu_b = 8'h00;
  stack_reg_e sreg = SRC_ACC;
  logic cload = 1'b0;
  logic cval = 1'b0;
  logic [7:0] o_acc, o_index_x, o_index_y, o_condition_flags;
  logic [15:0] o_program_counter, o_stack_pointer;
  logic o_index_sel_y, o_irq_pending, o_irq_entry, o_busy;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  int entries = 0;
  int busy_cycles = 0;
  alu_kind_e kinds[6] = '{ALU_ADD, ALU_ADD, ALU_ADC, ALU_SUB, ALU_AND, ALU_MOVE};
  logic [7:0] va[6] = '{8'h0f, 8'h80, 8'h01, 8'h00, 8'hf0, 8'h00};
  logic [7:0] vb[6] = '{8'h01, 8'h80, 8'h01, 8'h01, 8'h0f, 8'h80};
  logic [7:0] vr[6] = '{8'h10, 8'h00, 8'h03, 8'hff, 8'h00, 8'h80};
  logic [7:0] vf[6] = '{8'hf0, 8'he3, 8'he0, 8'he5, 8'he3, 8'he5};

  always #4 i_ref_clk = ~i_ref_clk;

  seq_partner_model i_partner (.i_ref_clk, .i_rst, .i_step, .i_raise, .o_boundary(boundary), .o_irq_req(irq_req));

  cpu_core_regs i_dut (
    .i_ref_clk, .i_rst, .i_instr_boundary(boundary), .i_prefix_op(ops[12]),
    .i_acc_we(ops[14]), .i_acc_wdata(wdata), .i_index_we(ops[13]), .i_index_wdata(wdata),
    .i_pc_load(ops[15]), .i_pc_wdata(wide), .i_pc_inc(1'b0),
    .i_alu_valid(ops[7]), .i_alu_kind(kind), .i_alu_a(alu_a), .i_alu_b(alu_b), .i_alu_to_acc(1'b1),
    .i_set_carry_op(ops[8]), .i_clear_carry_op(ops[9]), .i_carry_load(cload), .i_carry_value(cval),
    .i_mask_interrupts_op(ops[10]), .i_unmask_interrupts_op(ops[11]),
    .i_push_op(ops[0]), .i_pop_op(ops[1]), .i_stack_reg(sreg), .i_call_op(ops[2]), .i_call_target(wide),
    .i_return_op(ops[3]), .i_interrupt_return_op(ops[4]), .i_stack_pointer_reload_op(ops[5]),
    .i_sp_low_we(ops[6]), .i_sp_low_wdata(wdata), .i_irq_req(irq_req), .i_trap_op(1'b0),
    .i_irq_vector(16'h4000), .o_acc, .o_index_x, .o_index_y, .o_index_sel_y, .o_program_counter,
    .o_condition_flags, .o_stack_pointer, .o_irq_pending, .o_irq_entry, .o_busy
  );

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    #1;
    while (o_busy !== 1'b0 && n < 20) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
  endtask

  task automatic op(input logic [15:0] v);
    @(posedge i_ref_clk);
    ops <= v;
    @(posedge i_ref_clk);
    ops <= 16'h0000;
    wait_idle();
  endtask

  // boundary or request pulse from the stand-in, then let any frame finish
  task automatic line_pulse(input logic irq);
    @(posedge i_ref_clk);
    if (irq) i_raise <= 1'b1;
    else i_step <= 1'b1;
    @(posedge i_ref_clk);
    i_raise <= 1'b0;
    i_step <= 1'b0;
    @(posedge i_ref_clk);
    wait_idle();
  endtask

  // carry load as a bit-test, shift or rotate would drive it
  task automatic carry_ld(input logic v);
    @(posedge i_ref_clk);
    cload <= 1'b1;
    cval <= v;
    @(posedge i_ref_clk);
    cload <= 1'b0;
    wait_idle();
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge i_ref_clk) begin
    cycles++;
    if (o_busy === 1'b1) busy_cycles++;
    if (o_irq_entry === 1'b1) entries++;
    if (cycles == 3000) begin
      bad_count++;
      finish_test();
    end
  end

  initial begin
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    #1;
    chk("flags", 16'h00e8, 16'(o_condition_flags));
    chk("sp", 16'h00ff, o_stack_pointer);
    chk("pc", 16'h0000, o_program_counter);
    op(UNMASK);
    chk("flags", 16'h00e0, 16'(o_condition_flags));
    for (int k = 0; k < 6; k++) begin
      kind <= kinds[k];
      alu_a <= va[k];
      alu_b <= vb[k];
      op(ALU);
      chk("acc", 16'(vr[k]), 16'(o_acc));
      chk("flags", 16'(vf[k]), 16'(o_condition_flags));
    end
    op(CLRC);
    chk("flags", 16'h00e4, 16'(o_condition_flags));
    carry_ld(1'b1);
    chk("flags", 16'h00e5, 16'(o_condition_flags));
    carry_ld(1'b0);
    chk("flags", 16'h00e4, 16'(o_condition_flags));
    op(SETC);
    chk("flags", 16'h00e5, 16'(o_condition_flags));
    wdata <= 8'ha5;
    op(AW);
    op(PUSH);
    chk("sp", 16'h00fe, o_stack_pointer);
    sreg <= SRC_X;
    op(POP);
    chk("x", 16'h00a5, 16'(o_index_x));
    chk("sp", 16'h00ff, o_stack_pointer);
    sreg <= SRC_FLAGS;
    op(PUSH);
    op(CLRC);
    op(POP);
    chk("flags", 16'h00e5, 16'(o_condition_flags));
    wdata <= 8'hc0;
    op(SPW);
    chk("sp", 16'h00c0, o_stack_pointer);
    sreg <= SRC_ACC;
    op(PUSH);
    chk("sp", 16'h00ff, o_stack_pointer);
    wdata <= 8'h00;
    op(XW);
    sreg <= SRC_X;
    op(POP);
    chk("x", 16'h00a5, 16'(o_index_x));
    chk("sp", 16'h00c0, o_stack_pointer);
    op(RELOAD);
    chk("sp", 16'h00ff, o_stack_pointer);
    wide <= 16'h1234;
    op(PCW);
    wide <= 16'h0800;
    op(CALL);
    chk("pc", 16'h0800, o_program_counter);
    chk("sp", 16'h00fd, o_stack_pointer);
    op(RET);
    chk("pc", 16'h1234, o_program_counter);
    wdata <= 8'h77;
    op(PREFIX);
    chk("sel_y", 16'h0001, 16'(o_index_sel_y));
    op(XW);
    chk("y", 16'h0077, 16'(o_index_y));
    chk("x", 16'h00a5, 16'(o_index_x));
    line_pulse(1'b0);
    chk("sel_y", 16'h0000, 16'(o_index_sel_y));
    wdata <= 8'h3c;
    op(XW);
    wdata <= 8'h5a;
    op(AW);
    line_pulse(1'b1);
    chk("pending", 16'h0001, 16'(o_irq_pending));
    line_pulse(1'b0);
    chk("sp", 16'h00fa, o_stack_pointer);
    chk("pc", 16'h4000, o_program_counter);
    chk("flags", 16'h00ed, 16'(o_condition_flags));
    chk("pending", 16'h0000, 16'(o_irq_pending));
    chk("entries", 16'h0001, 16'(entries));
    wdata <= 8'h00;
    op(AW);
    op(XW);
    line_pulse(1'b1);
    line_pulse(1'b0);
    chk("sp", 16'h00fa, o_stack_pointer);
    chk("pending", 16'h0001, 16'(o_irq_pending));
    op(INTERRUPT_RETURN_OP);
    chk("acc", 16'h005a, 16'(o_acc));
    chk("x", 16'h003c, 16'(o_index_x));
    chk("pc", 16'h1234, o_program_counter);
    chk("sp", 16'h00ff, o_stack_pointer);
    chk("flags", 16'h00e5, 16'(o_condition_flags));
    chk("y", 16'h0077, 16'(o_index_y));
    line_pulse(1'b0);
    chk("sp", 16'h00fa, o_stack_pointer);
    chk("entries", 16'h0002, 16'(entries));
    chk("busy", 16'h0013, 16'(busy_cycles));
    finish_test();
  end
endmodule
